//--- pkg/frws_defines.vh
// Register offsets, field positions, unlock keys and region limits of the row write sequencer
`ifndef FRWS_DEFINES_VH
`define FRWS_DEFINES_VH
`define FRWS_OFS_ADDR_LOW    12'h81a
`define FRWS_OFS_ADDR_HIGH   12'h81b
`define FRWS_OFS_WDATA_LOW   12'h81c
`define FRWS_OFS_WDATA_HIGH  12'h81d
`define FRWS_OFS_CTRL        12'h81e
`define FRWS_OFS_UNLOCK_KEY  12'h81f
`define FRWS_OFS_DONE        12'h820
`define FRWS_CTRL_RD         0
`define FRWS_CTRL_WR         1
`define FRWS_CTRL_PROGRAM_ENABLE       2
`define FRWS_CTRL_WRERR      3
`define FRWS_CTRL_FREE       4
`define FRWS_CTRL_LATCH_ONLY       5
`define FRWS_CTRL_REGSEL     6
`define FRWS_DONE_FLAG       0
`define FRWS_DONE_IE         1
`define FRWS_KEY_FIRST       8'h55
`define FRWS_KEY_SECOND      8'haa
`define FRWS_LATCH_BLANK     15'h7fff
`define FRWS_LATCH_COUNT     32
`define FRWS_UID_LO          16'h8000
`define FRWS_UID_HI          16'h8003
`define FRWS_ID_LO           16'h8005
`define FRWS_ID_HI           16'h8006
`define FRWS_CFG_LO          16'h8007
`define FRWS_CFG_HI          16'h800b
`define FRWS_INFO_LO         16'h8100
`define FRWS_INFO_HI         16'h82ff
`define FRWS_EE_LO           16'hf000
`define FRWS_EE_HI           16'hf0ff
`define FRWS_CMD_READ        2'h0
`define FRWS_CMD_ERASE       2'h1
`define FRWS_CMD_WRITE       2'h2
`endif

//--- src/frws_top.v
// Flash row write sequencer: register file, unlock check, write latches and flash array sequencing
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "frws_defines.vh"
module frws_top #(
   parameter AW = 12,
   parameter DW = 14
) (
   input  wire          clk,
   input  wire          rst_n,
   input  wire [AW-1:0] reg_addr,
   input  wire [7:0]    reg_wdata,
   input  wire          reg_wr,
   input  wire          reg_rd,
   output reg  [7:0]    reg_rdata_r,
   input  wire          write_protect,
   output reg           fl_req_r,
   output reg  [1:0]    fl_cmd_r,
   output reg  [15:0]   fl_addr_r,
   output reg  [DW-1:0] fl_wdata_r,
   input  wire          fl_ack,
   input  wire [DW-1:0] fl_rdata,
   output reg           cpu_stall_r,
   output reg           irq_r
);
   localparam NL = `FRWS_LATCH_COUNT;
   localparam [14:0] BLANK_FULL = `FRWS_LATCH_BLANK;
   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_LATCH = 3'h1;
   localparam [2:0] S_PROG  = 3'h2;
   localparam [2:0] S_ERASE = 3'h3;
   localparam [2:0] S_WORD  = 3'h4;
   localparam [2:0] S_READ  = 3'h5;
   localparam [1:0] K_NONE  = 2'h0;
   localparam [1:0] K_FIRST = 2'h1;
   localparam [1:0] K_BOTH  = 2'h2;

   wire [DW-1:0]    blank = BLANK_FULL[DW-1:0];
   reg  [14:0]      addr_r;
   reg  [DW-1:0]    wdata_r;
   reg              regsel_r;
   reg              latch_only_r;
   reg              free_r;
   reg              wrerr_r;
   reg              program_enable_r;
   reg              wr_r;
   reg              rd_r;
   reg              done_flag_r;
   reg              done_ie_r;
   reg  [1:0]       key_r;
   reg  [2:0]       state_r;
   reg  [4:0]       cnt_r;
   reg  [NL*DW-1:0] latch_r;
   reg              latch_we;
   reg              latch_clr;
   reg  [7:0]       rd_nxt;

   wire        idle     = (state_r == S_IDLE);
   wire        wr_ctrl  = reg_wr && idle && (reg_addr == `FRWS_OFS_CTRL);
   wire        wr_key   = reg_wr && idle && (reg_addr == `FRWS_OFS_UNLOCK_KEY);
   wire        go_wr    = wr_ctrl && reg_wdata[`FRWS_CTRL_WR];
   wire        go_rd    = wr_ctrl && reg_wdata[`FRWS_CTRL_RD] && !reg_wdata[`FRWS_CTRL_WR];
   wire        unlocked = (key_r == K_BOTH);
   wire [15:0] full_adr = {regsel_r, addr_r};
   // Region windows only matter with the region bit set
   wire in_uid  = (full_adr >= `FRWS_UID_LO) && (full_adr <= `FRWS_UID_HI);
   wire in_id   = (full_adr >= `FRWS_ID_LO) && (full_adr <= `FRWS_ID_HI);
   wire in_cfg  = (full_adr >= `FRWS_CFG_LO) && (full_adr <= `FRWS_CFG_HI);
   wire in_info = (full_adr >= `FRWS_INFO_LO) && (full_adr <= `FRWS_INFO_HI);
   wire in_ee   = (full_adr >= `FRWS_EE_LO) && (full_adr <= `FRWS_EE_HI);
   wire reg_rdok = in_uid || in_id || in_cfg || in_info || in_ee;
   wire reg_wrok = in_uid || in_cfg || in_ee;
   // Latch loads ignore protection; only real array writes check it
   wire needs_wp = regsel_r ? (!reg_wrok || free_r || write_protect) :
                   (write_protect && (free_r || !latch_only_r));
   wire [DW-1:0] cur_latch = latch_r[cnt_r*DW +: DW];
   wire prog_last = (cnt_r == NL[4:0] - 5'h1);

   // One latch per entry; blank after every row write or erase
   genvar gi;
   generate
      for (gi = 0; gi < NL; gi = gi + 1) begin : g_latch
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               latch_r[gi*DW +: DW] <= {DW{1'b1}};
            end else if (latch_clr) begin
               latch_r[gi*DW +: DW] <= blank;
            end else if (latch_we && (addr_r[4:0] == gi)) begin
               latch_r[gi*DW +: DW] <= wdata_r;
            end
         end
      end
   endgenerate

   // Unlock tracker: any other access between the keys breaks it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         key_r <= K_NONE;
      end else if (wr_key) begin
         if (reg_wdata == `FRWS_KEY_FIRST) begin
            key_r <= K_FIRST;
         end else if (key_r == K_FIRST && reg_wdata == `FRWS_KEY_SECOND) begin
            key_r <= K_BOTH;
         end else begin
            key_r <= K_NONE;
         end
      end else if (reg_wr || reg_rd) begin
         key_r <= K_NONE;
      end
   end

   // Register writes, sequencer and flash array handshake
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_r      <= 15'h0000;
         wdata_r     <= {DW{1'b0}};
         regsel_r    <= 1'b0;
         latch_only_r      <= 1'b0;
         free_r      <= 1'b0;
         wrerr_r     <= 1'b0;
         program_enable_r      <= 1'b0;
         wr_r        <= 1'b0;
         rd_r        <= 1'b0;
         done_flag_r <= 1'b0;
         done_ie_r   <= 1'b0;
         state_r     <= S_IDLE;
         cnt_r       <= 5'h00;
         latch_we    <= 1'b0;
         latch_clr   <= 1'b0;
         fl_req_r    <= 1'b0;
         fl_cmd_r    <= `FRWS_CMD_READ;
         fl_addr_r   <= 16'h0000;
         fl_wdata_r  <= {DW{1'b0}};
         cpu_stall_r <= 1'b0;
         irq_r       <= 1'b0;
      end else begin
         latch_we  <= 1'b0;
         latch_clr <= 1'b0;
         irq_r     <= done_flag_r && done_ie_r;
         if (reg_wr && idle) begin
            case (reg_addr)
               `FRWS_OFS_ADDR_LOW:   addr_r[7:0]    <= reg_wdata;
               `FRWS_OFS_ADDR_HIGH:  addr_r[14:8]   <= reg_wdata[6:0];
               `FRWS_OFS_WDATA_LOW:  wdata_r[7:0]   <= reg_wdata;
               `FRWS_OFS_WDATA_HIGH: wdata_r[13:8]  <= reg_wdata[5:0];
               `FRWS_OFS_CTRL: begin
                  regsel_r <= reg_wdata[`FRWS_CTRL_REGSEL];
                  latch_only_r   <= reg_wdata[`FRWS_CTRL_LATCH_ONLY];
                  free_r   <= reg_wdata[`FRWS_CTRL_FREE];
                  program_enable_r   <= reg_wdata[`FRWS_CTRL_PROGRAM_ENABLE];
                  wrerr_r  <= reg_wdata[`FRWS_CTRL_WRERR];
               end
               `FRWS_OFS_DONE: begin
                  done_ie_r <= reg_wdata[`FRWS_DONE_IE];
                  if (!reg_wdata[`FRWS_DONE_FLAG]) begin
                     done_flag_r <= 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
         case (state_r)
            S_IDLE: begin
               if (go_wr) begin
                  if (!unlocked) begin
                     wrerr_r <= 1'b1;
                  end else if (!reg_wdata[`FRWS_CTRL_PROGRAM_ENABLE]) begin
                     wr_r <= 1'b0;
                  end else if (needs_wp) begin
                     wr_r    <= 1'b0;
                     wrerr_r <= 1'b1;
                  end else if (free_r) begin
                     wr_r        <= 1'b1;
                     state_r     <= S_ERASE;
                     fl_req_r    <= 1'b1;
                     fl_cmd_r    <= `FRWS_CMD_ERASE;
                     fl_addr_r   <= {regsel_r, addr_r[14:5], 5'h00};
                     cpu_stall_r <= 1'b1;
                  end else if (regsel_r) begin
                     wr_r        <= 1'b1;
                     state_r     <= S_WORD;
                     fl_req_r    <= 1'b1;
                     fl_cmd_r    <= `FRWS_CMD_WRITE;
                     fl_addr_r   <= full_adr;
                     fl_wdata_r  <= wdata_r;
                     cpu_stall_r <= 1'b1;
                  end else begin
                     wr_r     <= 1'b1;
                     latch_we <= 1'b1;
                     cnt_r    <= 5'h00;
                     state_r  <= latch_only_r ? S_LATCH : S_PROG;
                  end
               end else if (go_rd) begin
                  if (regsel_r && !reg_rdok) begin
                     wdata_r <= {DW{1'b0}};
                  end else begin
                     rd_r      <= 1'b1;
                     state_r   <= S_READ;
                     fl_req_r  <= 1'b1;
                     fl_cmd_r  <= `FRWS_CMD_READ;
                     fl_addr_r <= full_adr;
                  end
               end
            end
            S_LATCH: begin
               wr_r    <= 1'b0;
               state_r <= S_IDLE;
            end
            S_PROG: begin
               // No erase is issued here; target row must already be blank
               cpu_stall_r <= 1'b1;
               if (!fl_req_r) begin
                  fl_req_r   <= 1'b1;
                  fl_cmd_r   <= `FRWS_CMD_WRITE;
                  fl_addr_r  <= {1'b0, addr_r[14:5], cnt_r};
                  fl_wdata_r <= cur_latch;
               end else if (fl_ack) begin
                  fl_req_r <= 1'b0;
                  cnt_r    <= cnt_r + 5'h01;
                  if (prog_last) begin
                     latch_clr   <= 1'b1;
                     wr_r        <= 1'b0;
                     done_flag_r <= 1'b1;
                     cpu_stall_r <= 1'b0;
                     state_r     <= S_IDLE;
                  end
               end
            end
            S_ERASE, S_WORD: begin
               if (fl_ack) begin
                  fl_req_r    <= 1'b0;
                  latch_clr   <= 1'b1;
                  wr_r        <= 1'b0;
                  done_flag_r <= 1'b1;
                  cpu_stall_r <= 1'b0;
                  state_r     <= S_IDLE;
               end
            end
            S_READ: begin
               if (fl_ack) begin
                  fl_req_r <= 1'b0;
                  wdata_r  <= fl_rdata;
                  rd_r     <= 1'b0;
                  state_r  <= S_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // Read mux; unmapped offsets read zero
   always @* begin
      rd_nxt = 8'h00;
      case (reg_addr)
         `FRWS_OFS_ADDR_LOW:   rd_nxt = addr_r[7:0];
         `FRWS_OFS_ADDR_HIGH:  rd_nxt = {1'b0, addr_r[14:8]};
         `FRWS_OFS_WDATA_LOW:  rd_nxt = wdata_r[7:0];
         `FRWS_OFS_WDATA_HIGH: rd_nxt = {2'b00, wdata_r[13:8]};
         `FRWS_OFS_CTRL:       rd_nxt = {1'b0, regsel_r, latch_only_r, free_r, wrerr_r, program_enable_r, wr_r, rd_r};
         `FRWS_OFS_DONE:       rd_nxt = {6'h00, done_ie_r, done_flag_r};
         default:              rd_nxt = 8'h00;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata_r <= rd_nxt;
      end else begin
         reg_rdata_r <= 8'h00;
      end
   end
endmodule // frws_top
`default_nettype wire

//--- verif/frws_properties.sv
// Port checker of the flash row write sequencer
`timescale 1ns/1ns
`default_nettype none
`include "frws_defines.vh"
module frws_checker #(
   parameter AW = 12,
   parameter DW = 14
) (
   input wire logic          clk,
   input wire logic          rst_n,
   input wire logic [AW-1:0] reg_addr,
   input wire logic [7:0]    reg_wdata,
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [7:0]    reg_rdata_r,
   input wire logic          write_protect,
   input wire logic          fl_req_r,
   input wire logic [1:0]    fl_cmd_r,
   input wire logic [15:0]   fl_addr_r,
   input wire logic [DW-1:0] fl_wdata_r,
   input wire logic          fl_ack,
   input wire logic [DW-1:0] fl_rdata,
   input wire logic          cpu_stall_r,
   input wire logic          irq_r
);
   wire        wr_now  = fl_req_r && fl_cmd_r == `FRWS_CMD_WRITE;
   wire        row_ack = wr_now && fl_ack && !fl_addr_r[15];
   wire [15:0] fa      = fl_addr_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_req_stable:
      assert property (fl_req_r && !fl_ack |=> fl_req_r && $stable({fl_cmd_r, fl_addr_r, fl_wdata_r}))
      else $error("flash request changed before ack");
   a_req_release:
      assert property (fl_req_r && fl_ack |=> !fl_req_r)
      else $error("flash request held after ack");
   a_erase_row_base:
      assert property (fl_req_r && fl_cmd_r == `FRWS_CMD_ERASE |-> fa[4:0] == 5'h00)
      else $error("erase not at row base");
   a_stall_busy:
      assert property (fl_req_r && fl_cmd_r != `FRWS_CMD_READ |-> cpu_stall_r)
      else $error("no stall during erase or write");
   a_protect_erase:
      assert property ($rose(fl_req_r) && fl_cmd_r == `FRWS_CMD_ERASE
                       |-> !($past(write_protect) && $past(write_protect, 2)))
      else $error("erase started on protected target");
   a_row_next_word:
      assert property (row_ack && fa[4:0] != 5'h1f |=> !fl_req_r ##1 wr_now && fa == $past(fa, 2) + 16'h0001)
      else $error("row words out of order");
   a_row_last_word:
      assert property (row_ack && fa[4:0] == 5'h1f |=> (!fl_req_r && !cpu_stall_r) [*2])
      else $error("row program ran past last latch");
   a_region_write:
      assert property (wr_now && fa[15] |-> fa <= `FRWS_UID_HI || (fa >= `FRWS_CFG_LO && fa <= `FRWS_CFG_HI)
                       || (fa >= `FRWS_EE_LO && fa <= `FRWS_EE_HI))
      else $error("write into read-only region");
endmodule // frws_checker
bind frws_top frws_checker #(.AW(AW), .DW(DW)) i_checker (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata_r(reg_rdata_r), .write_protect(write_protect), .fl_req_r(fl_req_r), .fl_cmd_r(fl_cmd_r),
   .fl_addr_r(fl_addr_r), .fl_wdata_r(fl_wdata_r), .fl_ack(fl_ack), .fl_rdata(fl_rdata),
   .cpu_stall_r(cpu_stall_r), .irq_r(irq_r));
`default_nettype wire

//--- verif/test_flash_row_write_sequencer.sv
// Self-checking bench of the flash row write sequencer
`timescale 1ns/1ns
`default_nettype none
`include "frws_defines.vh"
module test_flash_row_write_sequencer;
   localparam logic [11:0] KEY = `FRWS_OFS_UNLOCK_KEY;
   localparam logic [11:0] CT  = `FRWS_OFS_CTRL;
   localparam logic [11:0] DL  = `FRWS_OFS_WDATA_LOW;
   localparam logic [15:0] RTAB [12] = '{16'h8000, 16'h8003, 16'h8004, 16'h8005, 16'h8006, 16'h800b,
                                         16'h800c, 16'h8100, 16'h82ff, 16'hf000, 16'hf0ff, 16'hf100};
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        write_protect = 1'b0;
   logic        fl_ack = 1'b0;
   logic [13:0] fl_rdata = 14'h0000;
   wire  [7:0]  reg_rdata_r;
   wire         fl_req_r;
   wire  [1:0]  fl_cmd_r;
   wire  [15:0] fl_addr_r;
   wire  [13:0] fl_wdata_r;
   wire         cpu_stall_r;
   wire         irq_r;
   int          failures = 0;
   int          n_tests = 0;
   int          dly = 0;
   logic        rd_seen = 1'b0;
   logic        in_req = 1'b0;
   logic [31:0] fe;
   logic [7:0]  exp_rd [$];
   logic [31:0] exp_fl [$];
   logic [13:0] lat [32];

   always #10 clk = ~clk;

   frws_top #(.AW(12), .DW(14)) i_dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_r(reg_rdata_r), .write_protect(write_protect), .fl_req_r(fl_req_r), .fl_cmd_r(fl_cmd_r),
      .fl_addr_r(fl_addr_r), .fl_wdata_r(fl_wdata_r), .fl_ack(fl_ack), .fl_rdata(fl_rdata),
      .cpu_stall_r(cpu_stall_r), .irq_r(irq_r));

   task automatic final_report;
      $display("Comparisons %0d, failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: read data %h, expected %h", $time, g, e);
      end
   endtask

   task automatic chk_fl(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: flash request %h, expected %h", $time, g, e);
      end
   endtask

   task automatic chk_irq(input logic g, input logic e);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: interrupt %h, expected %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_rd.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask

   task automatic go(input logic [7:0] c);
      wr(KEY, `FRWS_KEY_FIRST);
      wr(KEY, `FRWS_KEY_SECOND);
      wr(CT, c);
   endtask

   task automatic set_ad(input logic [14:0] a, input logic [13:0] v);
      wr(`FRWS_OFS_ADDR_LOW, a[7:0]);
      wr(`FRWS_OFS_ADDR_HIGH, {1'b0, a[14:8]});
      wr(DL, v[7:0]);
      wr(`FRWS_OFS_WDATA_HIGH, {2'b00, v[13:8]});
   endtask

   // Bounded wait until the flash side is quiet
   task automatic settle;
      int i;
      for (i = 0; i < 2000 && (exp_fl.size() != 0 || fl_req_r || cpu_stall_r); i++) @(negedge clk);
      if (i == 2000) begin
         failures++;
         final_report();
      end
      repeat (4) @(posedge clk);
   endtask

   function automatic logic ok_wr(input logic [15:0] x);
      return x <= `FRWS_UID_HI || (x >= `FRWS_CFG_LO && x <= `FRWS_CFG_HI) || (x >= `FRWS_EE_LO && x <= `FRWS_EE_HI);
   endfunction

   function automatic logic ok_rd(input logic [15:0] x);
      return ok_wr(x) || (x >= `FRWS_ID_LO && x <= `FRWS_ID_HI) || (x >= `FRWS_INFO_LO && x <= `FRWS_INFO_HI);
   endfunction

   // Read data stands only in the cycle after the strobe
   always @(posedge clk) rd_seen <= reg_rd;
   always @(negedge clk) if (rd_seen) chk_rd(reg_rdata_r, exp_rd.pop_front());

   // Flash array stand-in with a random acknowledge delay
   always @(posedge clk) begin
      if (fl_ack) begin
         fl_ack <= 1'b0;
         in_req <= 1'b0;
      end else if (fl_req_r && !in_req) begin
         in_req <= 1'b1;
         dly <= $urandom % 3;
         fe = exp_fl.size() != 0 ? exp_fl.pop_front() : 32'hxxxxxxxx;
         chk_fl({fl_cmd_r, fl_addr_r, (fl_cmd_r == `FRWS_CMD_WRITE ? fl_wdata_r : 14'h0000)}, fe);
      end else if (fl_req_r && dly == 0) begin
         fl_ack <= 1'b1;
         fl_rdata <= fl_addr_r[13:0] ^ 14'h2a5a;
      end else if (fl_req_r) begin
         dly <= dly - 1;
      end
   end

   initial begin
      #200000;
      failures++;
      final_report();
   end

   initial begin
      int k, j;
      logic [14:0] a;
      logic [13:0] v;
      void'($urandom(32'hecbf99a0));
      for (k = 0; k < 32; k++) lat[k] = 14'h3fff;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd(12'h800, 8'h00);
      a = 15'($urandom);
      a[0] = 1'b1;
      set_ad(a, 14'h0000);
      wr(CT, 8'h14);
      exp_fl.push_back({`FRWS_CMD_ERASE, 1'b0, a[14:5], 5'h00, 14'h0000});
      go(8'h16);
      settle();
      rd(`FRWS_OFS_DONE, 8'h01);
      wr(`FRWS_OFS_DONE, 8'h03);
      repeat (2) @(posedge clk);
      @(negedge clk) chk_irq(irq_r, 1'b1);
      wr(`FRWS_OFS_DONE, 8'h00);
      repeat (2) @(posedge clk);
      @(negedge clk) chk_irq(irq_r, 1'b0);
      rd(`FRWS_OFS_DONE, 8'h00);
      wr(CT, 8'h04);
      write_protect <= 1'b1;
      go(8'h06);
      settle();
      write_protect <= 1'b0;
      rd(CT, 8'h0c);
      wr(CT, 8'h24);
      for (k = 0; k < 5; k++) begin
         v = 14'($urandom);
         a[4:0] = k[4:0];
         lat[k] = v;
         set_ad(a, v);
         go(8'h26);
         repeat (3) @(posedge clk);
      end
      // Broken unlock: a read between the two keys
      a[4:0] = 5'h05;
      set_ad(a, 14'h1234);
      wr(KEY, `FRWS_KEY_FIRST);
      rd(DL, 8'h34);
      wr(KEY, `FRWS_KEY_SECOND);
      wr(CT, 8'h26);
      repeat (3) @(posedge clk);
      rd(CT, 8'h2c);
      // Second pass proves latches went blank after the first
      for (j = 0; j < 2; j++) begin
         wr(CT, 8'h04);
         v = 14'($urandom);
         a[4:0] = 5'h1f;
         lat[31] = v;
         set_ad(a, v);
         for (k = 0; k < 32; k++) exp_fl.push_back({`FRWS_CMD_WRITE, 1'b0, a[14:5], k[4:0], lat[k]});
         go(8'h06);
         settle();
         for (k = 0; k < 32; k++) lat[k] = 14'h3fff;
      end
      for (k = 0; k < 12; k++) begin
         a = RTAB[k][14:0];
         set_ad(a, 14'($urandom));
         wr(CT, 8'h40);
         if (ok_rd(RTAB[k])) exp_fl.push_back({`FRWS_CMD_READ, RTAB[k], 14'h0000});
         wr(CT, 8'h41);
         settle();
         v = ok_rd(RTAB[k]) ? (a[13:0] ^ 14'h2a5a) : 14'h0000;
         rd(DL, v[7:0]);
         rd(`FRWS_OFS_WDATA_HIGH, {2'b00, v[13:8]});
         v = 14'($urandom);
         set_ad(a, v);
         wr(CT, 8'h44);
         if (ok_wr(RTAB[k])) exp_fl.push_back({`FRWS_CMD_WRITE, RTAB[k], v});
         go(8'h46);
         settle();
         rd(CT, ok_wr(RTAB[k]) ? 8'h44 : 8'h4c);
      end
      final_report();
   end
endmodule // test_flash_row_write_sequencer
`default_nettype wire
